// File: src/gpio_return_pkg.sv
package gpio_return_pkg;

	// ==========================================================================
	// Register offsets.
	localparam logic [7:0] ADDR_PIN_LEVEL     = 8'h0e;
	localparam logic [7:0] ADDR_INPUT_GATE    = 8'h0f;
	localparam logic [7:0] ADDR_PULSE_CFG     = 8'h18;
	localparam logic [7:0] ADDR_HIGH_UPPER    = 8'h19;
	localparam logic [7:0] ADDR_HIGH_LOWER    = 8'h1a;
	localparam logic [7:0] ADDR_LOW_UPPER     = 8'h1b;
	localparam logic [7:0] ADDR_LOW_LOWER     = 8'h1c;
	localparam logic [7:0] ADDR_PORT_SEL      = 8'h4c;
	localparam logic [7:0] ADDR_RATE          = 8'h58;
	localparam logic [7:0] ADDR_MAP_A         = 8'h6e;
	localparam logic [7:0] ADDR_MAP_B         = 8'h6f;
	localparam logic [7:0] ADDR_PULLDOWN_GATE = 8'hbe;

	// ==========================================================================
	// Reset values.
	localparam logic [7:0]  RST_GATE     = 8'h00;
	localparam logic [7:0]  RST_CFG      = 8'h00;
	localparam logic [15:0] RST_COUNT    = 16'h0000;
	localparam logic [7:0]  RST_MAP      = 8'h00;
	localparam logic [2:0]  RST_RATE     = 3'h0;
	localparam logic [7:0]  RST_PORT_SEL = 8'h01;

	// ==========================================================================
	// Field positions and encodings.
	localparam int         PORT_SEL_RD_POS = 4;
	localparam logic [2:0] RATE_2P5M       = 3'h0;
	localparam logic [3:0] SRC_PORT0       = 4'h0;
	localparam logic [3:0] SRC_PORT1       = 4'h1;
	localparam logic [3:0] SRC_PIN_FIRST   = 4'h8;
	localparam logic [3:0] SRC_PIN_LAST    = 4'hb;
	localparam logic [3:0] MAP_PULSE       = 4'ha;

	// ==========================================================================
	// Timing: one generator tick is one return-link frame.
	localparam int CLK_PERIOD_NS   = 5;
	localparam int LINK_BIT_NS     = 400;
	localparam int LINK_FRAME_BITS = 30;
	localparam int TICK_NS         = LINK_FRAME_BITS * LINK_BIT_NS;
	localparam int TICK_CYCLES     = TICK_NS / CLK_PERIOD_NS;

	// ==========================================================================
	// Types.
	typedef struct packed {
		logic [3:0] src;          // Pulse source select.
		logic       spare;        // Reads back as written, no effect.
		logic       start_level;  // Level at generator start.
		logic       duty_even;    // 1: 50/50, 0: separate high and low.
		logic       gen_on;       // Internal generator enable.
	} pulse_cfg_t;

	typedef struct packed {
		logic [15:0] high;
		logic [15:0] low;
	} pulse_counts_t;

	typedef enum logic [2:0] {
		ST_IDLE = 3'b000,
		ST_ADDR = 3'b001,
		ST_ACK  = 3'b011,
		ST_RECV = 3'b010,
		ST_SEND = 3'b110,
		ST_RACK = 3'b111
	} i2c_state_t;

endpackage : gpio_return_pkg

// File: src/frame_pulse_gen.sv
`timescale 1ns/100ps
`default_nettype none
module frame_pulse_gen (
	input  wire logic                          mclk_i,     // System clock.
	input  wire logic                          rstn_i,     // Synchronised reset, active low.
	input  wire gpio_return_pkg::pulse_cfg_t   cfg_i,      // Generator configuration.
	input  wire gpio_return_pkg::pulse_counts_t counts_i,  // High and low counts.
	input  wire logic                          tick_run_i, // Selected tick source is valid.
	output logic                               pulse_o     // Generated level.
);
	import gpio_return_pkg::*;

	localparam logic [15:0] TICK_LAST = 16'(TICK_CYCLES - 1);

	logic        on_d_r;
	logic [15:0] tick_cnt_r;
	logic [15:0] left_r;
	logic        level_r;
	logic [15:0] gap_r;
	logic        gap_ok_r;

	// ==========================================================================
	// Decode.
	wire start     = cfg_i.gen_on & ~on_d_r;
	wire tick      = cfg_i.gen_on & ~start & tick_run_i & (tick_cnt_r == TICK_LAST); // RULE9
	wire [15:0] len_hi  = (counts_i.high == 16'h0000) ? 16'h0001 : counts_i.high;
	wire [15:0] len_lo  = (counts_i.low == 16'h0000) ? 16'h0001 : counts_i.low;
	wire [15:0] len_start = (cfg_i.start_level | cfg_i.duty_even) ? len_hi : len_lo; // RULE13
	wire [15:0] len_next  = (~level_r | cfg_i.duty_even) ? len_hi : len_lo; // RULE14

	assign pulse_o = level_r;

	// Frame tick divider restarts with the generator so the first level is a whole number of ticks long.
	always_ff @(posedge mclk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			on_d_r     <= 1'b0;
			tick_cnt_r <= 16'h0000;
		end else begin
			on_d_r     <= cfg_i.gen_on;
			if (!cfg_i.gen_on || start || tick)
				tick_cnt_r <= 16'h0000;
			else if (tick_run_i)
				tick_cnt_r <= tick_cnt_r + 16'h0001;
		end
	end

	// Level runs free while enabled; no trigger beyond the enable is needed.
	always_ff @(posedge mclk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			level_r <= 1'b0;
			left_r  <= 16'h0001;
		end else if (start) begin
			level_r <= cfg_i.start_level; // RULE16
			left_r  <= len_start;
		end else if (tick) begin // RULE10
			if (left_r <= 16'h0001) begin
				level_r <= ~level_r; // RULE18
				left_r  <= len_next;
			end else begin
				left_r <= left_r - 16'h0001;
			end
		end
	end

	// ==========================================================================
	// Checks.
	always_ff @(posedge mclk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			gap_r    <= 16'h0000;
			gap_ok_r <= 1'b0;
		end else if (start || !cfg_i.gen_on || !tick_run_i) begin
			gap_r    <= 16'h0000;
			gap_ok_r <= 1'b0;
		end else begin
			gap_r    <= tick ? 16'h0000 : gap_r + 16'h0001;
			gap_ok_r <= gap_ok_r | tick;
		end
	end

	default clocking cb @(posedge mclk_i); endclocking
	default disable iff (!rstn_i);

	a_tick_gap: assert property (tick && gap_ok_r |-> gap_r == TICK_LAST) // RULE9
		else $error("Generator tick spacing wrong.");
	a_start_level: assert property (start |=> level_r == $past(cfg_i.start_level)) // RULE16
		else $error("Generator did not start at programmed level.");
	a_level_flip: assert property (tick && left_r == 16'h0001 |=> level_r != $past(level_r)) // RULE18
		else $error("Level did not switch when count expired.");
	a_level_hold: assert property (tick && left_r > 16'h0001
		|=> level_r == $past(level_r) && left_r == $past(left_r) - 16'h0001) // RULE14
		else $error("Level changed before count expired.");
	a_even_reload: assert property (tick && left_r == 16'h0001 && cfg_i.duty_even
		|=> left_r == $past(len_hi)) // RULE13
		else $error("Even duty reload not the high count.");
	c_level_flip: cover property (tick && left_r == 16'h0001 ##1 cfg_i.gen_on);

endmodule : frame_pulse_gen
`default_nettype wire

// File: src/return_link_gpio.sv
`timescale 1ns/100ps
`default_nettype none
// Functional notes
// RULE1: Pins act as inputs; each return signal picks any of four pins.
// RULE2: One pin may feed several return signals on either port.
// RULE3: Frame pulse can be picked instead of a pin for any return signal.
// RULE4: Pin level view shows every pin level regardless of its configuration.
// RULE5: Each pin has input and pulldown disables; both paths enabled after reset.
// RULE6: Input gating sits at 0x0F, pulldown gating at 0xBE, one bit per pin.
// RULE7: Generator off and source 0x8..0xB takes the frame pulse from pin 0..3.
// RULE8: Frame pulse reaches a port only where its pin map selects it.
// RULE9: Generator tick equals 30-bit, 400 ns return-link frame, 12 us.
// RULE10: Enabled generator repeats the pulse continuously without further trigger.
// RULE11: Enable bit set to 1 selects internal pulse generation.
// RULE12: Four-bit source field picks tick source; 0x0 means port 0 frame period.
// RULE13: Duty style 0 uses separate high and low counts; 1 gives 50/50.
// RULE14: Pulse high for high count ticks, low for low count ticks.
// RULE15: 16-bit counts in byte registers 0x19/0x1A high, 0x1B/0x1C low.
// RULE16: Start level bit sets pulse level when generation begins.
// RULE17: Rate select 0x0 chooses 2.5 Mbps, which sets the tick period.
// RULE18: Count ticks per level, switch on expiry, reload new level's count.
// RULE19: Host programs counts, rate and mapping before enabling the generator.
module return_link_gpio #(
	parameter logic [6:0] DEV_ADDR = 7'h2a // Target address; value is arbitrary.
) (
	input  wire logic             mclk_i,         // System clock, 200 MHz.
	input  wire logic             rstn_i,         // Asynchronous reset, active low.
	input  wire logic [3:0]       gpio_pin_i,     // Pad levels of the four pins.
	input  wire logic             scl_i,          // Serial control clock.
	input  wire logic             sda_i,          // Serial control data in.
	output logic                  sda_o,          // Serial control data out.
	output logic                  sda_oen_o,      // Low while driving data low.
	output logic [3:0]            pulldown_on_o,  // Internal pulldown enables.
	output logic [1:0][3:0]       ret_sig_o       // Return-link pin signals per port.
);
	import gpio_return_pkg::*;

	// ==========================================================================
	// Reset release.
	logic [1:0] rst_sync_r;
	wire        rst_n = rst_sync_r[1];

	always_ff @(posedge mclk_i or negedge rstn_i) begin
		if (!rstn_i)
			rst_sync_r <= 2'b00;
		else
			rst_sync_r <= {rst_sync_r[0], 1'b1};
	end

	// ==========================================================================
	// Register state.
	logic [3:0]      pin_lvl_r;
	logic [7:0]      input_gate_r;
	logic [7:0]      pd_gate_r;
	pulse_cfg_t      cfg_r;
	pulse_counts_t   counts_r;
	logic [7:0]      port_sel_r;
	logic [1:0][2:0] rate_r;
	logic [1:0][7:0] map_a_r;
	logic [1:0][7:0] map_b_r;

	// ==========================================================================
	// Control bus synchronisers and edge detection.
	logic [1:0] scl_s_r;
	logic [1:0] sda_s_r;
	logic       scl_d_r;
	logic       sda_d_r;

	always_ff @(posedge mclk_i or negedge rst_n) begin
		if (!rst_n) begin
			scl_s_r <= 2'b11;
			sda_s_r <= 2'b11;
			scl_d_r <= 1'b1;
			sda_d_r <= 1'b1;
		end else begin
			scl_s_r <= {scl_s_r[0], scl_i};
			sda_s_r <= {sda_s_r[0], sda_i};
			scl_d_r <= scl_s_r[1];
			sda_d_r <= sda_s_r[1];
		end
	end

	// Start and stop only count while the clock line is high on both samples.
	wire scl_rise  = scl_s_r[1] & ~scl_d_r;
	wire scl_fall  = ~scl_s_r[1] & scl_d_r;
	wire scl_high  = scl_s_r[1] & scl_d_r;
	wire start_det = scl_high & sda_d_r & ~sda_s_r[1];
	wire stop_det  = scl_high & ~sda_d_r & sda_s_r[1];

	// ==========================================================================
	// Control bus target.
	i2c_state_t state_r;
	logic [3:0] cnt_r;
	logic [7:0] shift_r;
	logic [7:0] ptr_r;
	logic       rw_r;
	logic       have_ptr_r;
	logic       nack_r;
	logic [7:0] rd_data;

	wire byte_done = scl_fall & (cnt_r == 4'h8);
	wire wr_stb    = byte_done & (state_r == ST_RECV) & have_ptr_r;
	wire load_rd   = scl_fall & (((state_r == ST_ACK) & rw_r) | ((state_r == ST_RACK) & ~nack_r));

	// Byte level sequencer; register pointer auto-increments on every data byte.
	always_ff @(posedge mclk_i or negedge rst_n) begin
		if (!rst_n) begin
			state_r    <= ST_IDLE;
			cnt_r      <= 4'h0;
			shift_r    <= 8'h00;
			ptr_r      <= 8'h00;
			rw_r       <= 1'b0;
			have_ptr_r <= 1'b0;
			nack_r     <= 1'b0;
			sda_oen_o  <= 1'b1;
		end else if (start_det) begin
			state_r    <= ST_ADDR;
			cnt_r      <= 4'h0;
			have_ptr_r <= 1'b0;
			sda_oen_o  <= 1'b1;
		end else if (stop_det) begin
			state_r   <= ST_IDLE;
			sda_oen_o <= 1'b1;
		end else begin
			case (state_r)
				ST_ADDR, ST_RECV: begin
					if (scl_rise) begin
						shift_r <= {shift_r[6:0], sda_s_r[1]};
						cnt_r   <= cnt_r + 4'h1;
					end else if (byte_done) begin
						cnt_r <= 4'h0;
						if (state_r == ST_ADDR) begin
							if (shift_r[7:1] == DEV_ADDR) begin
								rw_r      <= shift_r[0];
								sda_oen_o <= 1'b0;
								state_r   <= ST_ACK;
							end else begin
								state_r <= ST_IDLE;
							end
						end else begin
							if (!have_ptr_r)
								ptr_r <= shift_r;
							else
								ptr_r <= ptr_r + 8'h01;
							have_ptr_r <= 1'b1;
							sda_oen_o  <= 1'b0;
							state_r    <= ST_ACK;
						end
					end
				end
				ST_ACK, ST_RACK: begin
					if (scl_rise && state_r == ST_RACK)
						nack_r <= sda_s_r[1];
					else if (load_rd) begin
						shift_r   <= rd_data;
						sda_oen_o <= rd_data[7];
						ptr_r     <= ptr_r + 8'h01;
						cnt_r     <= 4'h0;
						state_r   <= ST_SEND;
					end else if (scl_fall) begin
						sda_oen_o <= 1'b1;
						cnt_r     <= 4'h0;
						state_r   <= (state_r == ST_ACK) ? ST_RECV : ST_IDLE;
					end
				end
				ST_SEND: begin
					if (scl_rise)
						cnt_r <= cnt_r + 4'h1;
					else if (byte_done) begin
						sda_oen_o <= 1'b1;
						state_r   <= ST_RACK;
					end else if (scl_fall) begin
						shift_r   <= {shift_r[6:0], 1'b0};
						sda_oen_o <= shift_r[6];
					end
				end
				default: begin
					state_r <= ST_IDLE;
				end
			endcase
		end
	end

	// ==========================================================================
	// Read decode; paged registers read the port named by the read select bit.
	wire rd_port = port_sel_r[PORT_SEL_RD_POS];

	always_comb begin
		if (ptr_r == ADDR_PIN_LEVEL)
			rd_data = {4'h0, pin_lvl_r}; // RULE4
		else if (ptr_r == ADDR_INPUT_GATE)
			rd_data = input_gate_r;
		else if (ptr_r == ADDR_PULSE_CFG)
			rd_data = cfg_r;
		else if (ptr_r == ADDR_HIGH_UPPER)
			rd_data = counts_r.high[15:8];
		else if (ptr_r == ADDR_HIGH_LOWER)
			rd_data = counts_r.high[7:0];
		else if (ptr_r == ADDR_LOW_UPPER)
			rd_data = counts_r.low[15:8];
		else if (ptr_r == ADDR_LOW_LOWER)
			rd_data = counts_r.low[7:0];
		else if (ptr_r == ADDR_PORT_SEL)
			rd_data = port_sel_r;
		else if (ptr_r == ADDR_RATE)
			rd_data = {5'h00, rate_r[rd_port]};
		else if (ptr_r == ADDR_MAP_A)
			rd_data = map_a_r[rd_port];
		else if (ptr_r == ADDR_MAP_B)
			rd_data = map_b_r[rd_port];
		else if (ptr_r == ADDR_PULLDOWN_GATE)
			rd_data = pd_gate_r;
		else
			rd_data = 8'h00;
	end

	// ==========================================================================
	// Register writes; paged writes go to every port whose write bit is set.
	always_ff @(posedge mclk_i or negedge rst_n) begin
		if (!rst_n) begin
			pin_lvl_r    <= 4'h0;
			input_gate_r <= RST_GATE; // RULE5
			pd_gate_r    <= RST_GATE; // RULE5
			cfg_r        <= RST_CFG;
			counts_r     <= {RST_COUNT, RST_COUNT};
			port_sel_r   <= RST_PORT_SEL;
			rate_r       <= {RST_RATE, RST_RATE};
			map_a_r      <= {RST_MAP, RST_MAP};
			map_b_r      <= {RST_MAP, RST_MAP};
		end else begin
			pin_lvl_r <= gpio_pin_i; // RULE4
			if (wr_stb) begin
				if (ptr_r == ADDR_INPUT_GATE)
					input_gate_r <= shift_r; // RULE6
				else if (ptr_r == ADDR_PULLDOWN_GATE)
					pd_gate_r <= shift_r; // RULE6
				else if (ptr_r == ADDR_PULSE_CFG)
					cfg_r <= shift_r; // RULE11
				else if (ptr_r == ADDR_HIGH_UPPER)
					counts_r.high[15:8] <= shift_r; // RULE15
				else if (ptr_r == ADDR_HIGH_LOWER)
					counts_r.high[7:0] <= shift_r; // RULE15
				else if (ptr_r == ADDR_LOW_UPPER)
					counts_r.low[15:8] <= shift_r; // RULE15
				else if (ptr_r == ADDR_LOW_LOWER)
					counts_r.low[7:0] <= shift_r; // RULE15
				else if (ptr_r == ADDR_PORT_SEL)
					port_sel_r <= shift_r;
				for (int p = 0; p < 2; p++) begin
					if (port_sel_r[p] && ptr_r == ADDR_RATE)
						rate_r[p] <= shift_r[2:0];
					else if (port_sel_r[p] && ptr_r == ADDR_MAP_A)
						map_a_r[p] <= shift_r;
					else if (port_sel_r[p] && ptr_r == ADDR_MAP_B)
						map_b_r[p] <= shift_r;
				end
			end
		end
	end

	// ==========================================================================
	// Pin gating, tick source and frame pulse source.
	wire [3:0] pin_in   = pin_lvl_r & ~input_gate_r[3:0]; // RULE5
	wire       ext_pick = (cfg_r.src >= SRC_PIN_FIRST) & (cfg_r.src <= SRC_PIN_LAST);
	wire       tick_run = ((cfg_r.src == SRC_PORT0) & (rate_r[0] == RATE_2P5M)) // RULE12 RULE17
	                    | ((cfg_r.src == SRC_PORT1) & (rate_r[1] == RATE_2P5M));
	logic      gen_level;
	wire       frame_pulse = cfg_r.gen_on ? gen_level // RULE11
	                       : (ext_pick & pin_in[cfg_r.src[1:0]]); // RULE7

	frame_pulse_gen u_gen (
		.mclk_i     (mclk_i),
		.rstn_i     (rst_n),
		.cfg_i      (cfg_r),
		.counts_i   (counts_r),
		.tick_run_i (tick_run),
		.pulse_o    (gen_level)
	);

	// Each return signal has its own selector, so one pin may feed many signals.
	// Both byte lanes use an in-range offset so no arm of the select reaches below bit 0.
	logic [1:0][3:0] ret_nxt;
	logic [3:0]      sel;
	always_comb begin
		sel = 4'h0;
		for (int p = 0; p < 2; p++) begin
			for (int i = 0; i < 4; i++) begin
				sel = (i < 2) ? map_a_r[p][4*(i%2) +: 4] : map_b_r[p][4*(i%2) +: 4];
				if (sel == MAP_PULSE)
					ret_nxt[p][i] = frame_pulse; // RULE3 RULE8
				else if (sel < 4'h4)
					ret_nxt[p][i] = pin_in[sel[1:0]]; // RULE1 RULE2
				else
					ret_nxt[p][i] = 1'b0;
			end
		end
	end

	// Outputs registered; pulldown enable is the inverse of its disable bit.
	always_ff @(posedge mclk_i or negedge rst_n) begin
		if (!rst_n) begin
			ret_sig_o     <= 8'h00;
			pulldown_on_o <= 4'hf;
			sda_o         <= 1'b0;
		end else begin
			sda_o         <= 1'b0; // Open drain: only the enable ever moves.
			ret_sig_o     <= ret_nxt;
			pulldown_on_o <= ~pd_gate_r[3:0]; // RULE5
		end
	end

	// ==========================================================================
	// Checks.
	default clocking cb @(posedge mclk_i); endclocking
	default disable iff (!rst_n);

	a_level_read: assert property (load_rd && ptr_r == ADDR_PIN_LEVEL
		|=> shift_r == {4'h0, $past(pin_lvl_r)}) // RULE4
		else $error("Pin level view read wrong.");
	a_map_pin: assert property (map_a_r[0][3:0] < 4'h4
		|=> ret_sig_o[0][0] == $past(pin_in[map_a_r[0][1:0]])) // RULE1
		else $error("Pin map output does not follow pin.");
	a_map_pulse: assert property (map_b_r[1][7:4] == MAP_PULSE
		|=> ret_sig_o[1][3] == $past(frame_pulse)) // RULE8
		else $error("Mapped frame pulse missing.");
	a_ext_source: assert property (!cfg_r.gen_on && cfg_r.src == 4'h9
		|-> frame_pulse == pin_in[1]) // RULE7
		else $error("External pulse not from selected pin.");
	a_pd_follow: assert property (wr_stb && ptr_r == ADDR_PULLDOWN_GATE
		|=> ##1 pulldown_on_o == ~$past(shift_r[3:0], 2)) // RULE5
		else $error("Pulldown enable not updated.");
	c_reg_write: cover property (wr_stb && ptr_r == ADDR_PULSE_CFG);
	c_reg_read: cover property (load_rd ##[1:300] state_r == ST_RACK);
	c_pulse_out: cover property (cfg_r.gen_on && $rose(ret_sig_o[0][0]));

endmodule : return_link_gpio
`default_nettype wire

// File: verification/return_link_monitor.sv
`timescale 1ns/100ps
`default_nettype none
// ==========================================================================
// Far-end receiver of one return-link pin signal.
module return_link_monitor (
	input  wire logic        mclk_i,   // System clock.
	input  wire logic        rstn_i,   // Reset, active low.
	input  wire logic        sig_i,    // Received return-link pin signal.
	output logic      [31:0] hi_len_o, // Length of the last complete high run.
	output logic      [31:0] lo_len_o, // Length of the last complete low run.
	output logic      [31:0] edges_o   // Number of level changes seen.
);
	logic        prev_r;
	logic [31:0] run_r;

	// Runs are measured in clock cycles, so a tick error of one cycle shows.
	always_ff @(posedge mclk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			prev_r   <= 1'b0;
			run_r    <= 32'h0;
			hi_len_o <= 32'h0;
			lo_len_o <= 32'h0;
			edges_o  <= 32'h0;
		end else if (sig_i !== prev_r) begin
			if (prev_r) begin
				hi_len_o <= run_r;
			end else begin
				lo_len_o <= run_r;
			end
			run_r   <= 32'h1;
			prev_r  <= sig_i;
			edges_o <= edges_o + 32'h1;
		end else begin
			run_r <= run_r + 32'h1;
		end
	end
endmodule : return_link_monitor
`default_nettype wire

// File: verification/return_link_gpio_test.sv
`timescale 1ns/100ps
`default_nettype none
module return_link_gpio_test;
	import gpio_return_pkg::*;
	// ==========================================================================
	// Stimulus, wiring and the far end.
	localparam logic [6:0] TARGET = 7'h2a; // Arbitrary target address.
	logic            mclk = 1'b0;
	logic            rst_n = 1'b0;
	logic [3:0]      pins = 4'h0;
	logic            scl = 1'b1;
	logic            sda = 1'b1;
	logic            sda_o;
	logic            sda_oen;
	logic [3:0]      pd_on;
	logic [1:0][3:0] ret;
	logic [31:0]     hi_len;
	logic [31:0]     lo_len;
	logic [31:0]     edges;
	int              err_total = 0;
	int              samples_checked = 0;
	// The pull-up wins unless the master drives low or the target enables its low driver.
	wire             sda_bus = sda & (sda_oen | sda_o);

	always #2.5 mclk = ~mclk;

	return_link_gpio #(.DEV_ADDR(TARGET)) uut (.mclk_i(mclk), .rstn_i(rst_n), .gpio_pin_i(pins),
		.scl_i(scl), .sda_i(sda_bus), .sda_o(sda_o), .sda_oen_o(sda_oen),
		.pulldown_on_o(pd_on), .ret_sig_o(ret));
	return_link_monitor far_end (.mclk_i(mclk), .rstn_i(rst_n), .sig_i(ret[0][0]),
		.hi_len_o(hi_len), .lo_len_o(lo_len), .edges_o(edges));

	// ==========================================================================
	// Shared tasks.
	task automatic clks(input int n);
		repeat (n) @(posedge mclk);
	endtask : clks

	task automatic stop_test;
		$display("checks made %0d, mismatches %0d", samples_checked, err_total);
		if (err_total == 0 && samples_checked > 0) begin
			$display("ALL CHECKS OK");
		end else begin
			$display("CHECKS NOT OK");
		end
		$finish;
	endtask : stop_test

	task automatic check(input logic [31:0] got, input logic [31:0] exp);
		samples_checked++;
		if (got !== exp) begin
			err_total++;
			$display("unexpected at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : check

	// One bus bit: eight cycles low, eight high, sampled mid-high.
	task automatic bit_io(input logic b, output logic s);
		sda <= b;
		clks(4);
		scl <= 1'b1;
		clks(4);
		s = sda_bus;
		clks(4);
		scl <= 1'b0;
		clks(4);
	endtask : bit_io

	task automatic byte_io(input logic [7:0] d, output logic [7:0] q);
		for (int i = 7; i >= 0; i--) begin
			bit_io(d[i], q[i]);
		end
	endtask : byte_io

	task automatic send(input logic [7:0] d);
		logic [7:0] q;
		logic       a;
		byte_io(d, q);
		bit_io(1'b1, a);
		check({31'h0, a}, 32'h0);
	endtask : send

	task automatic start_cond;
		sda <= 1'b1;
		clks(4);
		scl <= 1'b1;
		clks(8);
		sda <= 1'b0;
		clks(8);
		scl <= 1'b0;
		clks(4);
	endtask : start_cond

	task automatic stop_cond;
		sda <= 1'b0;
		clks(4);
		scl <= 1'b1;
		clks(8);
		sda <= 1'b1;
		clks(8);
	endtask : stop_cond

	task automatic reg_wr(input logic [7:0] a, input logic [7:0] d);
		start_cond;
		send({TARGET, 1'b0});
		send(a);
		send(d);
		stop_cond;
	endtask : reg_wr

	// The master answers the single data byte with a refusal to end the read.
	task automatic reg_rd(input logic [7:0] a, output logic [7:0] d);
		logic n;
		start_cond;
		send({TARGET, 1'b0});
		send(a);
		start_cond;
		send({TARGET, 1'b1});
		byte_io(8'hff, d);
		bit_io(1'b1, n);
		stop_cond;
	endtask : reg_rd

	task automatic rd_check(input logic [7:0] a, input logic [7:0] exp);
		logic [7:0] d;
		reg_rd(a, d);
		check({24'h0, d}, {24'h0, exp});
	endtask : rd_check

	task automatic wait_edges(input logic [31:0] target);
		int n;
		n = 0;
		while (edges < target && n < 40000) begin
			clks(1);
			n++;
		end
		if (n >= 40000) begin
			err_total++;
			$display("unexpected at %0t: edges %h expected %h", $time, edges, target);
			stop_test;
		end
	endtask : wait_edges

	// ==========================================================================
	// Scenarios.
	task automatic test_reset;
		check({28'h0, pd_on}, 32'hf);
		check({24'h0, ret}, 32'h0);
		check({31'h0, sda_o}, 32'h0);
		rd_check(ADDR_INPUT_GATE, 8'h00);
		rd_check(ADDR_PULLDOWN_GATE, 8'h00);
		rd_check(ADDR_RATE, {5'h0, RATE_2P5M});
		rd_check(8'h30, 8'h00);
		reg_wr(ADDR_PULLDOWN_GATE, 8'h05);
		check({28'h0, pd_on}, 32'ha);
		rd_check(ADDR_PULLDOWN_GATE, 8'h05);
		$display("test finished: reset and pulldown");
	endtask : test_reset

	// Port 0 uses four different pins, port 1 reuses pin 3 twice.
	task automatic test_pin_map;
		logic [7:0] d;
		reg_wr(ADDR_MAP_A, 8'h10);
		reg_wr(ADDR_MAP_B, 8'h32);
		reg_wr(ADDR_PORT_SEL, 8'h02);
		reg_wr(ADDR_MAP_A, 8'h33);
		reg_wr(ADDR_MAP_B, 8'h00);
		pins <= 4'ha;
		clks(4);
		check({24'h0, ret}, 32'h3a);
		reg_rd(ADDR_PIN_LEVEL, d);
		check({28'h0, d[3:0]}, 32'ha);
		reg_wr(ADDR_INPUT_GATE, 8'h08);
		check({24'h0, ret}, 32'h02);
		reg_rd(ADDR_PIN_LEVEL, d);
		check({28'h0, d[3:0]}, 32'ha);
		reg_wr(ADDR_INPUT_GATE, 8'h00);
		$display("test finished: pin mapping and input gating");
	endtask : test_pin_map

	// Each external source code, with the other pins driven opposite.
	task automatic test_external;
		reg_wr(ADDR_PORT_SEL, 8'h01);
		reg_wr(ADDR_MAP_A, 8'ha0);
		for (int k = 0; k < 4; k++) begin
			reg_wr(ADDR_PULSE_CFG, {SRC_PIN_FIRST + 4'(k), 4'h0});
			pins <= 4'(1 << k);
			clks(4);
			check({31'h0, ret[0][1]}, 32'h1);
			check({28'h0, ret[1]}, {28'h0, {2{k == 0}}, {2{k == 3}}});
			pins <= ~4'(1 << k);
			clks(4);
			check({31'h0, ret[0][1]}, 32'h0);
		end
		$display("test finished: external pulse");
	endtask : test_external

	// Counts and mapping go in before the enable, so no run uses stale values.
	task automatic test_generator;
		logic [7:0]  cnt [4] = '{8'h00, 8'h02, 8'h00, 8'h03};
		logic [31:0] base;
		for (int i = 0; i < 4; i++) begin
			reg_wr(ADDR_HIGH_UPPER + 8'(i), cnt[i]);
		end
		rd_check(ADDR_HIGH_LOWER, 8'h02);
		rd_check(ADDR_LOW_LOWER, 8'h03);
		reg_wr(ADDR_MAP_A, {4'h0, MAP_PULSE});
		reg_wr(ADDR_PULSE_CFG, {SRC_PORT0, 4'h5});
		base = edges;
		check({31'h0, ret[0][0]}, 32'h1);
		wait_edges(base + 32'h3);
		check(hi_len, 32'(2 * TICK_CYCLES));
		check(lo_len, 32'(3 * TICK_CYCLES));
		reg_wr(ADDR_PULSE_CFG, {SRC_PORT0, 4'h3});
		base = edges;
		wait_edges(base + 32'h3);
		check(hi_len, 32'(2 * TICK_CYCLES));
		check(lo_len, 32'(2 * TICK_CYCLES));
		// Any rate other than the slowest leaves the tick source without ticks.
		reg_wr(ADDR_RATE, 8'h01);
		rd_check(ADDR_RATE, 8'h01);
		base = edges;
		clks(3 * TICK_CYCLES);
		check(edges, base);
		$display("test finished: internal generator");
	endtask : test_generator

	// ==========================================================================
	// Main sequence.
	initial begin
		repeat (10) @(posedge mclk);
		rst_n <= 1'b1;
		clks(8);
		test_reset;
		test_pin_map;
		test_external;
		test_generator;
		stop_test;
	end
endmodule : return_link_gpio_test
`default_nettype wire
